//--- core/tim_pkg.sv
// Register map, field positions and codes of the timer channel block
package tim_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_VALH0 = 8'h08;
  localparam logic [7:0] OFS_VALL0 = 8'h0C;
  localparam logic [7:0] OFS_VALH1 = 8'h10;
  localparam logic [7:0] OFS_VALL1 = 8'h14;

  // Control and status byte layout
  localparam int FLAG_BIT = 7;
  localparam int IE_BIT   = 6;
  localparam int BUF_BIT  = 5;
  localparam int MSA_BIT  = 4;
  localparam int ELSB_BIT = 3;
  localparam int ELSA_BIT = 2;
  localparam int TOV_BIT  = 1;
  localparam int MAX_BIT  = 0;

  // Reset values
  localparam logic [6:0]  CTRL_RST  = 7'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Edge/level select codes (capture edge or compare action)
  localparam logic [1:0] ELS_OFF  = 2'h0;
  localparam logic [1:0] ELS_TOG  = 2'h1;
  localparam logic [1:0] ELS_CLR  = 2'h2;
  localparam logic [1:0] ELS_SET  = 2'h3;

endpackage : tim_pkg

//--- core/pin_sync.sv
// Two-flop synchroniser for the channel pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule : pin_sync

//--- core/chan_flag.sv
// Channel event flag with two-step read-then-write-zero clear
`timescale 1ns/1ps
module chan_flag (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic set,
  input  wire logic rd_seen,
  input  wire logic wr_zero,
  output logic      flag
);

  logic armed_r;

  // Arm on a read that showed the flag set; a new event disarms
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed_r <= 1'b0;
    end else if (set || wr_zero) begin
      armed_r <= 1'b0;
    end else if (rd_seen) begin
      armed_r <= 1'b1;
    end
  end

  // Set wins over clear; writing one does nothing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (wr_zero && armed_r) begin
      flag <= 1'b0;
    end
  end

  a_flag_set_wins: assert property (
    @(posedge clk) disable iff (!rstn) set |=> flag)
    else $error("flag not set after event");

  a_flag_needs_arm: assert property (
    @(posedge clk) disable iff (!rstn)
    flag && !armed_r |=> flag)
    else $error("flag cleared without prior read");

endmodule : chan_flag

//--- core/tim_channels.sv
// Two capture/compare/PWM channels of the timer with APB registers
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
module tim_channels (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [15:0] COUNTER,
  input  wire logic        OVERFLOW,
  input  wire logic        COUNTER_HALT,
  input  wire logic [1:0]  CH_PIN_IN,
  output logic      [1:0]  CH_PIN_OUT,
  output logic      [1:0]  CH_PIN_OE,
  output logic      [1:0]  CH_IRQ
);

  logic [6:0]  ctrl_r [2];
  logic [15:0] val_r [2];
  logic [15:0] cmp_val [2];
  logic [1:0]  els_e [2];
  logic [1:0]  flag, cap_mode, cmp_mode, match, capture, cmp_sel;
  logic [1:0]  rlock_r, wlock_r, maxe_r, pin_s, pin_d_r;
  logic [1:0]  rd_ctrl, wr_ctrl, rd_hi, rd_lo, wr_hi, wr_lo;
  logic [15:0] cnt_prev_r;
  logic        access, wr_go, rd_go, hit, bufmode, sel_r, cnt_new;
  logic [7:0]  rd_byte;

  assign bufmode = ctrl_r[0][tim_pkg::BUF_BIT];
  assign access  = PSEL && PENABLE && PREADY;
  assign wr_go   = access && PWRITE;
  assign rd_go   = access && !PWRITE;
  assign cnt_new = COUNTER != cnt_prev_r;

  // No wait states: ready in every access phase
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
    end
  end

  // Read mux and unmapped-address decode
  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (PADDR)
      tim_pkg::OFS_CTRL0: rd_byte = {flag[0], ctrl_r[0]};
      tim_pkg::OFS_CTRL1: rd_byte = {flag[1], ctrl_r[1]};
      tim_pkg::OFS_VALH0: rd_byte = val_r[0][15:8];
      tim_pkg::OFS_VALL0: rd_byte = val_r[0][7:0];
      tim_pkg::OFS_VALH1: rd_byte = val_r[1][15:8];
      tim_pkg::OFS_VALL1: rd_byte = val_r[1][7:0];
      default:            hit     = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA  <= tim_pkg::RDATA_RST;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PRDATA  <= {24'h00_0000, rd_byte};
      PSLVERR <= !hit;
    end
  end

  // Pin inputs cross into the core clock
  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk  (CORE_CLK),
    .rstn (RSTN),
    .din  (CH_PIN_IN),
    .dout (pin_s)
  );

  // Edge history and counter change detect
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_d_r    <= 2'h0;
      cnt_prev_r <= 16'h0000;
    end else begin
      pin_d_r    <= pin_s;
      cnt_prev_r <= COUNTER;
    end
  end

  // Buffered pair swaps active value register at overflow
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sel_r <= 1'b0;
    end else if (!bufmode) begin
      sel_r <= 1'b0;
    end else if (OVERFLOW) begin
      sel_r <= !sel_r;
    end
  end

  for (genvar x = 0; x < 2; x++) begin : g_ch
    localparam logic [7:0] OC = (x == 0) ? tim_pkg::OFS_CTRL0
                                         : tim_pkg::OFS_CTRL1;
    localparam logic [7:0] OH = (x == 0) ? tim_pkg::OFS_VALH0
                                         : tim_pkg::OFS_VALH1;
    localparam logic [7:0] OL = (x == 0) ? tim_pkg::OFS_VALL0
                                         : tim_pkg::OFS_VALL1;
    logic       buf_x, msa, tov, edge_ok, full_lvl, out_nxt;
    logic [1:0] els_raw;

    // Access strobes at the completing edge
    assign rd_ctrl[x] = rd_go && PADDR == OC;
    assign wr_ctrl[x] = wr_go && PADDR == OC;
    assign rd_hi[x]   = rd_go && PADDR == OH;
    assign rd_lo[x]   = rd_go && PADDR == OL;
    assign wr_hi[x]   = wr_go && PADDR == OH;
    assign wr_lo[x]   = wr_go && PADDR == OL;

    // Effective mode decode
    assign buf_x   = (x == 0) && bufmode;
    assign msa     = ctrl_r[x][tim_pkg::MSA_BIT];
    assign tov     = ctrl_r[x][tim_pkg::TOV_BIT];
    assign els_raw = ctrl_r[x][tim_pkg::ELSB_BIT:tim_pkg::ELSA_BIT];
    assign els_e[x] = (x == 1 && bufmode) ? tim_pkg::ELS_OFF
                                          : els_raw;
    assign cap_mode[x] = els_e[x] != tim_pkg::ELS_OFF
                         && !buf_x && !msa;
    assign cmp_mode[x] = els_e[x] != tim_pkg::ELS_OFF
                         && (buf_x || msa);
    assign cmp_sel[x]  = msa || bufmode;

    // Active compare value; channel 0 alternates when buffered
    assign cmp_val[x] = buf_x ? val_r[sel_r] : val_r[x];

    // Capture edge qualification
    always_comb begin
      unique case (els_e[x])
        tim_pkg::ELS_TOG: edge_ok = pin_s[x] && !pin_d_r[x];
        tim_pkg::ELS_CLR: edge_ok = !pin_s[x] && pin_d_r[x];
        tim_pkg::ELS_SET: edge_ok = pin_s[x] != pin_d_r[x];
        default:          edge_ok = 1'b0;
      endcase
    end

    assign capture[x] = cap_mode[x] && edge_ok && !rlock_r[x]
                        && !COUNTER_HALT;
    assign match[x] = cmp_mode[x] && cnt_new && COUNTER == cmp_val[x]
                      && !(buf_x ? wlock_r[sel_r] : wlock_r[x]);

    // Control register; buffered bit only in channel 0
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
        ctrl_r[x] <= tim_pkg::CTRL_RST;
      end else if (wr_ctrl[x]) begin
        ctrl_r[x] <= PWDATA[6:0];
        if (x == 1) begin
          ctrl_r[x][tim_pkg::BUF_BIT] <= 1'b0;
        end
      end
    end

    // Value register, no reset; capture loads the counter
    always_ff @(posedge CORE_CLK) begin
      if (capture[x]) begin
        val_r[x] <= COUNTER;
      end else begin
        if (wr_hi[x]) begin
          val_r[x][15:8] <= PWDATA[7:0];
        end
        if (wr_lo[x]) begin
          val_r[x][7:0] <= PWDATA[7:0];
        end
      end
    end

    // Byte-pair coherency locks
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
        rlock_r[x] <= 1'b0;
        wlock_r[x] <= 1'b0;
      end else begin
        if (rd_lo[x] || !cap_mode[x]) begin
          rlock_r[x] <= 1'b0;
        end else if (rd_hi[x]) begin
          rlock_r[x] <= 1'b1;
        end
        if (wr_lo[x] || !cmp_sel[x]) begin
          wlock_r[x] <= 1'b0;
        end else if (wr_hi[x]) begin
          wlock_r[x] <= 1'b1;
        end
      end
    end

    // Event flag with two-step clear
    chan_flag u_flag (
      .clk     (CORE_CLK),
      .rstn    (RSTN),
      .set     (capture[x] || match[x]),
      .rd_seen (rd_ctrl[x] && PRDATA[tim_pkg::FLAG_BIT]),
      .wr_zero (wr_ctrl[x] && !PWDATA[tim_pkg::FLAG_BIT]),
      .flag    (flag[x])
    );

    // Full-duty bit sampled at period boundary
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
        maxe_r[x] <= 1'b0;
      end else if (OVERFLOW) begin
        maxe_r[x] <= ctrl_r[x][tim_pkg::MAX_BIT];
      end
    end

    // Output level: preset, overflow first, then compare action
    assign full_lvl = els_e[x] != tim_pkg::ELS_SET;
    always_comb begin
      out_nxt = CH_PIN_OUT[x];
      if (els_e[x] == tim_pkg::ELS_OFF) begin
        out_nxt = !msa;
      end else if (cmp_mode[x]) begin
        if (tov && maxe_r[x]) begin
          out_nxt = full_lvl;
        end else if (tov && OVERFLOW) begin
          out_nxt = !CH_PIN_OUT[x];
        end else if (match[x]) begin
          unique case (els_e[x])
            tim_pkg::ELS_TOG: out_nxt = !CH_PIN_OUT[x];
            tim_pkg::ELS_CLR: out_nxt = 1'b0;
            default:          out_nxt = 1'b1;
          endcase
        end
      end
    end

    // Pin drive, enable and interrupt request
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
        CH_PIN_OUT[x] <= 1'b0;
        CH_PIN_OE[x]  <= 1'b0;
        CH_IRQ[x]     <= 1'b0;
      end else begin
        CH_PIN_OUT[x] <= out_nxt;
        CH_PIN_OE[x]  <= cmp_mode[x];
        CH_IRQ[x]     <= flag[x] && ctrl_r[x][tim_pkg::IE_BIT];
      end
    end
  end

  a_irq_gated: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    !ctrl_r[0][tim_pkg::IE_BIT] |=> !CH_IRQ[0])
    else $error("irq raised while disabled");

  a_ch1_released: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    bufmode |=> !CH_PIN_OE[1])
    else $error("channel 1 pin driven in buffered mode");

  a_pin_off_float: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    els_e[0] == tim_pkg::ELS_OFF |=> !CH_PIN_OE[0])
    else $error("pin driven with select pair zero");

  a_preset_level: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    els_e[1] == tim_pkg::ELS_OFF
    |=> CH_PIN_OUT[1] == !$past(ctrl_r[1][tim_pkg::MSA_BIT]))
    else $error("preset level wrong");

  a_ovf_beats_cmp: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    cmp_mode[0] && OVERFLOW && match[0] && !maxe_r[0]
    && ctrl_r[0][tim_pkg::TOV_BIT]
    |=> CH_PIN_OUT[0] != $past(CH_PIN_OUT[0]))
    else $error("overflow toggle lost to compare");

  a_capture_load: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    capture[1] |=> val_r[1] == $past(COUNTER) && flag[1])
    else $error("capture did not load value and flag");

  a_read_lock: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    rlock_r[1] && !wr_hi[1] && !wr_lo[1] |=> $stable(val_r[1]))
    else $error("capture while high byte locked");

  a_full_duty: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    cmp_mode[0] && maxe_r[0] && ctrl_r[0][tim_pkg::TOV_BIT]
    ##1 $stable(els_e[0]) |-> CH_PIN_OUT[0] == (els_e[0] != 2'h3))
    else $error("full duty not held");

  a_write_lock: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    wlock_r[0] && !bufmode |-> !match[0])
    else $error("match during high byte write lock");

  a_buf_swap: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    bufmode && OVERFLOW |=> sel_r != $past(sel_r))
    else $error("buffered value select did not swap");

  a_ch1_ignored: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    bufmode |-> !cap_mode[1] && !cmp_mode[1])
    else $error("channel 1 active in buffered mode");

  a_max_latch: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    OVERFLOW |=> maxe_r[0] == $past(ctrl_r[0][tim_pkg::MAX_BIT]))
    else $error("full duty bit not latched at overflow");

endmodule : tim_channels

//--- dv/pin_model.sv
// Far-side model of the two channel pins
`timescale 1ns/1ps
module pin_model (
  input  wire logic [1:0] ext_lvl,
  input  wire logic [1:0] oe,
  input  wire logic [1:0] out,
  output logic      [1:0] pin
);
  // Channel owns the pin while enabled, else the outside source does
  always_comb pin = (oe & out) | (~oe & ext_lvl);
endmodule : pin_model

//--- dv/tb_top.sv
// Self-checking bench for the timer channel block
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [15:0] cnt;
  logic        ovf;
  logic        halt;
  logic [1:0]  ext;
  logic [1:0]  pin;
  logic [31:0] cv;
  logic [15:0] v;
  logic [15:0] w;
  logic        ep;
  int          err_count;
  int          n_compared;
  wire  [31:0] PRDATA;
  wire         PREADY;
  wire         PSLVERR;
  wire  [1:0]  CH_PIN_OUT;
  wire  [1:0]  CH_PIN_OE;
  wire  [1:0]  CH_IRQ;

  tim_channels DUT (.CORE_CLK(clk), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .COUNTER(cnt),
    .OVERFLOW(ovf), .COUNTER_HALT(halt), .CH_PIN_IN(pin),
    .CH_PIN_OUT(CH_PIN_OUT), .CH_PIN_OE(CH_PIN_OE), .CH_IRQ(CH_IRQ));

  pin_model PINS (.ext_lvl(ext), .oe(CH_PIN_OE), .out(CH_PIN_OUT),
    .pin(pin));

  // Verdict and end of run
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (PREADY === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      end_of_test();
    end
    rd = PRDATA;
    er = PSLVERR;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h00_0000, d}, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
    chk({31'h0000_0000, e}, {31'h0000_0000, exp_err});
  endtask : rd

  // Counter steps away from and then onto value x
  task automatic hit(input logic [15:0] x, input logic with_ovf);
    @(posedge clk);
    cnt <= x ^ 16'h0001;
    @(posedge clk);
    cnt <= x;
    ovf <= with_ovf;
    @(posedge clk);
    ovf <= 1'b0;
    @(negedge clk);
  endtask : hit

  // Core clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Main sequence
  initial begin
    rstn       = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0000_0000;
    cnt        = 16'h0000;
    ovf        = 1'b0;
    halt       = 1'b0;
    ext        = 2'b00;
    err_count  = 0;
    n_compared = 0;
    cv = $urandom(32'hE164_FC3E);
    v  = cv[15:0];
    w  = v ^ 16'h00F0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(negedge clk);
    chk(CH_PIN_OUT, 2'b11);
    chk(CH_PIN_OE, 2'b00);
    rd(tim_pkg::OFS_CTRL0, 32'h0000_0000, 1'b0);
    rd(8'h18, 32'h0000_0000, 1'b1);
    $display("test reset done");
    wr(tim_pkg::OFS_VALH0, v[15:8]);
    wr(tim_pkg::OFS_VALL0, v[7:0]);
    for (int k = 1; k < 4; k++) begin
      halt <= 1'b1;
      cnt  <= 16'h0000;
      wr(tim_pkg::OFS_CTRL0, (k == 2) ? 8'h40 : 8'h50);
      repeat (2) @(negedge clk);
      chk(CH_PIN_OUT[0], k == 2);
      wr(tim_pkg::OFS_CTRL0, 8'h50 | 8'(k << 2));
      halt <= 1'b0;
      hit(v, 1'b0);
      chk(CH_PIN_OUT[0], k != 2);
      chk(CH_PIN_OE[0], 1'b1);
      rd(tim_pkg::OFS_CTRL0, 32'h0000_00D0 | (k << 2), 1'b0);
      chk(CH_IRQ[0], 1'b1);
    end
    ep = 1'b1;
    wr(tim_pkg::OFS_CTRL0, 8'h54);
    rd(tim_pkg::OFS_CTRL0, 32'h0000_0054, 1'b0);
    chk(CH_IRQ[0], 1'b0);
    $display("test compare done");
    wr(tim_pkg::OFS_VALH0, v[15:8]);
    hit(v, 1'b0);
    chk(CH_PIN_OUT[0], ep);
    rd(tim_pkg::OFS_CTRL0, 32'h0000_0054, 1'b0);
    wr(tim_pkg::OFS_VALL0, v[7:0]);
    hit(v, 1'b0);
    ep = ~ep;
    chk(CH_PIN_OUT[0], ep);
    wr(tim_pkg::OFS_CTRL0, 8'h54);
    rd(tim_pkg::OFS_CTRL0, 32'h0000_00D4, 1'b0);
    chk(CH_IRQ[0], 1'b1);
    wr(tim_pkg::OFS_CTRL0, 8'h16);
    hit(v ^ 16'h0F00, 1'b1);
    ep = ~ep;
    chk(CH_PIN_OUT[0], ep);
    wr(tim_pkg::OFS_CTRL0, 8'h1E);
    hit(v, 1'b1);
    ep = ~ep;
    chk(CH_PIN_OUT[0], ep);
    wr(tim_pkg::OFS_CTRL0, 8'h1B);
    hit(v, 1'b0);
    chk(CH_PIN_OUT[0], 1'b0);
    hit(v ^ 16'h0F00, 1'b1);
    hit(v, 1'b0);
    chk(CH_PIN_OUT[0], 1'b1);
    wr(tim_pkg::OFS_CTRL0, 8'h1A);
    hit(v, 1'b0);
    chk(CH_PIN_OUT[0], 1'b1);
    hit(v ^ 16'h0F00, 1'b1);
    hit(v, 1'b0);
    chk(CH_PIN_OUT[0], 1'b0);
    $display("test overflow done");
    cv = $urandom;
    halt <= 1'b1;
    cnt  <= 16'h0000;
    wr(tim_pkg::OFS_CTRL1, 8'h04);
    halt <= 1'b0;
    rd(tim_pkg::OFS_CTRL1, 32'h0000_0004, 1'b0);
    wr(tim_pkg::OFS_CTRL1, 8'h04);
    cnt <= cv[15:0];
    ext <= 2'b10;
    repeat (6) @(posedge clk);
    rd(tim_pkg::OFS_CTRL1, 32'h0000_0084, 1'b0);
    chk(CH_IRQ[1], 1'b0);
    rd(tim_pkg::OFS_VALH1, {24'h00_0000, cv[15:8]}, 1'b0);
    cnt <= ~cv[15:0];
    ext <= 2'b00;
    repeat (4) @(posedge clk);
    ext <= 2'b10;
    repeat (6) @(posedge clk);
    rd(tim_pkg::OFS_VALL1, {24'h00_0000, cv[7:0]}, 1'b0);
    wr(tim_pkg::OFS_CTRL1, 8'h04);
    ext <= 2'b00;
    repeat (6) @(posedge clk);
    rd(tim_pkg::OFS_CTRL1, 32'h0000_0004, 1'b0);
    wr(tim_pkg::OFS_CTRL1, 8'h08);
    cv = $urandom;
    cnt <= cv[15:0];
    ext <= 2'b10;
    repeat (6) @(posedge clk);
    rd(tim_pkg::OFS_CTRL1, 32'h0000_0008, 1'b0);
    ext <= 2'b00;
    repeat (6) @(posedge clk);
    rd(tim_pkg::OFS_CTRL1, 32'h0000_0088, 1'b0);
    rd(tim_pkg::OFS_VALH1, {24'h00_0000, cv[15:8]}, 1'b0);
    rd(tim_pkg::OFS_VALL1, {24'h00_0000, cv[7:0]}, 1'b0);
    wr(tim_pkg::OFS_CTRL1, 8'h0C);
    ext <= 2'b10;
    repeat (6) @(posedge clk);
    rd(tim_pkg::OFS_CTRL1, 32'h0000_008C, 1'b0);
    $display("test capture done");
    wr(tim_pkg::OFS_CTRL1, 8'h3C);
    rd(tim_pkg::OFS_CTRL1, 32'h0000_001C, 1'b0);
    chk(CH_PIN_OE[1], 1'b1);
    wr(tim_pkg::OFS_VALH1, w[15:8]);
    wr(tim_pkg::OFS_VALL1, w[7:0]);
    halt <= 1'b1;
    cnt  <= 16'h0000;
    wr(tim_pkg::OFS_CTRL0, 8'h24);
    halt <= 1'b0;
    repeat (2) @(negedge clk);
    chk(CH_PIN_OE[1], 1'b0);
    hit(v, 1'b0);
    chk(CH_PIN_OUT[0], 1'b1);
    hit(w, 1'b1);
    chk(CH_PIN_OUT[0], 1'b1);
    hit(w, 1'b0);
    chk(CH_PIN_OUT[0], 1'b0);
    hit(v, 1'b0);
    chk(CH_PIN_OUT[0], 1'b0);
    $display("test buffered done");
    end_of_test();
  end
endmodule : tb_top
